// file: dv/flash_erase_ctl_chk.sv
// Checker for the erase/lock controller, seen at its top-level ports.
// Assumes one clock domain and a bind onto flash_erase_ctl.
`timescale 1ns/1ns
module flash_erase_ctl_chk
  import flash_ctl_pkg::*;
(
  input wire logic CLK, // Clock
  input wire logic RESET, // Sync reset
  input wire logic ERASE_REQ, // Request
  input wire logic [1:0] UNLOCK_MODE, // Unlock method
  input wire logic [ADDR_W-1:0] LOCK_LO, // Range low
  input wire logic [ADDR_W-1:0] LOCK_HI, // Range high
  input wire logic LOCK_EN, // Range enable
  input wire logic [ADDR_W-1:0] A, // Address pins
  input wire logic DQ_OE, // Data drive
  input wire logic CE_N, // Chip enable
  input wire logic WE_N, // Write strobe
  input wire logic OE_N, // Read strobe
  input wire logic WRITE_PROTECT_N, // Write protect
  input wire logic HIGH_VOLTAGE_EN, // 12V switch
  input wire logic PROGRAM_VOLTAGE_EN, // Program voltage
  input wire logic BUSY, // Busy
  input wire logic ERASE_DONE // Done pulse
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  // ----------------------------------------
  // Settle counter
  // ----------------------------------------
  // Cycles since 12V went on; saturates so it never wraps to zero
  logic [CNT_W-1:0] hv_cnt_q;
  always_ff @(posedge CLK) begin
    if (RESET || !HIGH_VOLTAGE_EN) begin
      hv_cnt_q <= '0;
    end else if (hv_cnt_q != '1) begin
      hv_cnt_q <= hv_cnt_q + 1'b1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_ONE_STROBE: assert property (WE_N || OE_N)
    else $error("read and write strobes low together");
  AST_WE_IN_CE: assert property (!WE_N |-> !CE_N && DQ_OE)
    else $error("write strobe without select or data");
  AST_LATCH_EDGE: assert property ($rose(WE_N) |->
    !CE_N && DQ_OE && $stable(A))
    else $error("address or data lost at strobe rise");
  // Held through the whole low time, so a fall-latching part also works
  AST_ADDR_HELD: assert property (!WE_N |=>
    $stable(A) && $stable(DQ_OE))
    else $error("address moved while write strobe low");
  // BUSY is registered from the state, so it rises one edge after take and is sampled high two edges on
  AST_TAKEN: assert property (ERASE_REQ && !BUSY |-> ##2 BUSY)
    else $error("idle request not taken");
  AST_DONE_ONE: assert property (ERASE_DONE |=>
    !ERASE_DONE && !BUSY)
    else $error("done not a single pulse at the end");
  AST_WP_MODE0: assert property (UNLOCK_MODE == UNLOCK_NONE &&
    BUSY |-> WRITE_PROTECT_N)
    else $error("boot block not kept unlocked");
  AST_WP_BOOT: assert property (UNLOCK_MODE == UNLOCK_WP &&
    !WE_N && A < PARAM0_BASE |-> WRITE_PROTECT_N)
    else $error("boot write while write protect low");
  AST_HV_SETTLE: assert property (HIGH_VOLTAGE_EN && !WE_N |->
    hv_cnt_q >= UNLOCK_SETTLE_CYC - 1)
    else $error("write before high voltage settled");
  AST_RANGE_CUT: assert property (!WE_N && LOCK_EN &&
    A >= LOCK_LO && A <= LOCK_HI |-> !PROGRAM_VOLTAGE_EN)
    else $error("program voltage on inside locked range");
endmodule

bind flash_erase_ctl flash_erase_ctl_chk i_chk (.CLK(CLK), .RESET(RESET),
  .ERASE_REQ(ERASE_REQ), .UNLOCK_MODE(UNLOCK_MODE), .LOCK_LO(LOCK_LO),
  .LOCK_HI(LOCK_HI), .LOCK_EN(LOCK_EN), .A(A), .DQ_OE(DQ_OE),
  .CE_N(CE_N), .WE_N(WE_N), .OE_N(OE_N),
  .WRITE_PROTECT_N(WRITE_PROTECT_N), .HIGH_VOLTAGE_EN(HIGH_VOLTAGE_EN),
  .PROGRAM_VOLTAGE_EN(PROGRAM_VOLTAGE_EN), .BUSY(BUSY),
  .ERASE_DONE(ERASE_DONE));

// file: dv/flash_model.sv
// Behavioural boot-block flash: lock table, erase and status register.
// Assumes the controller's pins; records erased block bases in log_q.
`timescale 1ns/1ns
module flash_model
  import flash_ctl_pkg::*;
(
  input wire logic ce_n, // Chip enable
  input wire logic we_n, // Write strobe
  input wire logic oe_n, // Read strobe
  input wire logic [ADDR_W-1:0] a, // Address
  input wire logic [DATA_W-1:0] ctl_dq, // Controller data
  input wire logic ctl_oe, // Controller drives
  input wire logic wp_n, // Write protect
  input wire logic rp_n, // Reset/power-down
  input wire logic hv_en, // Reset pin at 12V
  input wire logic pv_en, // Program voltage
  input wire logic slow, // Long erase time
  output logic [DATA_W-1:0] dq // Resolved data bus
);
  logic [7:0] sr = 8'h80;
  logic setup_q = 1'b0;
  logic [ADDR_W-1:0] log_q [$];
  // ----------------------------------------
  // Block map and lock table
  // ----------------------------------------
  function automatic logic [ADDR_W-1:0] base(input logic [ADDR_W-1:0] x);
    if (x < PARAM0_BASE) return BOOT_BASE;
    if (x < PARAM1_BASE) return PARAM0_BASE;
    if (x < SMALL_BASE) return PARAM1_BASE;
    if (x <= GROUP_TOP) return SMALL_BASE;
    return {x[17:16], 16'h0000};
  endfunction
  // Only the boot block has a lock of its own
  function automatic logic locked(input logic [ADDR_W-1:0] b);
    if (!pv_en || (!rp_n && !hv_en)) return 1'b1;
    if (hv_en) return 1'b0;
    return b == BOOT_BASE && !wp_n;
  endfunction
  // Locked blocks stay intact; status reports the refusal
  task automatic erase(input logic [ADDR_W-1:0] x);
    sr[7] = 1'b0;
    if (locked(base(x))) sr[5] = 1'b1;
    else log_q.push_back(base(x));
    sr[3] = !pv_en;
    fork
      #(slow ? 20000 : 400) sr[7] = 1'b1;
    join_none
  endtask
  // ----------------------------------------
  // Bus
  // ----------------------------------------
  // Address and data both taken at the rising write strobe
  always @(posedge we_n) begin
    if (!ce_n && (rp_n || hv_en)) begin
      if (setup_q && ctl_dq == CMD_ERASE_CONFIRM) erase(a);
      if (ctl_dq == CMD_CLEAR_STATUS) sr[5:3] = 3'b000;
      setup_q = ctl_dq == CMD_ERASE_SETUP;
    end
  end
  // Released bus shows the inverse, so stale data never looks valid
  assign dq = ctl_oe ? ctl_dq :
    (!ce_n && !oe_n) ? {8'h00, sr} : ~{8'h00, sr};
endmodule

// file: dv/testbench.sv
// Self-checking bench for the erase/lock controller.
// Assumes flash_model in dv/ stands on the flash pins.
`timescale 1ns/1ns
`define CHK(n, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) begin \
      err_total++; \
      $display("Error %s expected %0h seen %0h", n, e, g); \
    end \
  end
module testbench;
  import flash_ctl_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic erase_req = 1'b0;
  logic lock_en = 1'b0;
  logic slow = 1'b0;
  logic [ADDR_W-1:0] erase_addr = '0;
  logic [ADDR_W-1:0] lock_lo = '0;
  logic [ADDR_W-1:0] lock_hi = '0;
  logic [1:0] unlock_mode = '0;
  logic [DATA_W-1:0] dq_in, dq_out;
  logic [ADDR_W-1:0] a;
  logic dq_oe, ce_n, we_n, oe_n, wp_n, rp_n, hv_en, pv_en;
  logic busy, err, done;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [ADDR_W-1:0] grp [4] =
    '{BOOT_BASE, PARAM0_BASE, PARAM1_BASE, SMALL_BASE};
  flash_erase_ctl i_flash_erase_ctl (.CLK(clk), .RESET(reset),
    .ERASE_REQ(erase_req), .ERASE_ADDR(erase_addr),
    .UNLOCK_MODE(unlock_mode), .LOCK_LO(lock_lo), .LOCK_HI(lock_hi),
    .LOCK_EN(lock_en), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe),
    .A(a), .CE_N(ce_n), .WE_N(we_n), .OE_N(oe_n),
    .WRITE_PROTECT_N(wp_n), .RESET_POWERDOWN_N(rp_n),
    .HIGH_VOLTAGE_EN(hv_en), .PROGRAM_VOLTAGE_EN(pv_en), .BUSY(busy),
    .ERR(err), .ERASE_DONE(done));
  flash_model u_flash (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .a(a),
    .ctl_dq(dq_out), .ctl_oe(dq_oe), .wp_n(wp_n), .rp_n(rp_n),
    .hv_en(hv_en), .pv_en(pv_en), .slow(slow), .dq(dq_in));
  // ----------------------------------------
  // Clock, timeout and verdict
  // ----------------------------------------
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard, well beyond the slow-erase run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      close_out();
    end
  end
  // ----------------------------------------
  // Shared steps
  // ----------------------------------------
  task automatic start(input logic [ADDR_W-1:0] ad, input logic [1:0] md);
    @(posedge clk);
    #1;
    erase_addr = ad;
    unlock_mode = md;
    u_flash.log_q.delete();
    @(posedge clk);
    #1;
    erase_req = 1'b1;
    @(posedge clk);
    #1;
    erase_req = 1'b0;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 30000) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("done", 1'b1, done)
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Any member address erases the whole group, boot first
  task automatic t_group(input logic [ADDR_W-1:0] ad, input logic [1:0] md);
    start(ad, md);
    wait_done();
    `CHK("err", 1'b0, err)
    `CHK("count", 4, u_flash.log_q.size())
    for (int i = 0; i < 4; i++) begin
      `CHK("member", grp[i], u_flash.log_q[i])
    end
  endtask
  // Outside the group one block only; a request while busy is dropped
  task automatic t_single();
    start(18'h2abcd, 2'b00);
    @(posedge clk);
    #1;
    erase_addr = 18'h30000;
    erase_req = 1'b1;
    @(posedge clk);
    #1;
    erase_req = 1'b0;
    wait_done();
    `CHK("count", 1, u_flash.log_q.size())
    `CHK("block", 18'h20000, u_flash.log_q[0])
  endtask
  // Cut program voltage leaves the block intact and stops the group
  task automatic t_lock(input logic [ADDR_W-1:0] lo, hi, ad,
                        input logic [1:0] md, input int exp_n);
    lock_lo = lo;
    lock_hi = hi;
    lock_en = 1'b1;
    start(ad, md);
    wait_done();
    `CHK("err", 1'b1, err)
    `CHK("count", exp_n, u_flash.log_q.size())
    lock_en = 1'b0;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1;
    reset = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("rp_n", 1'b1, rp_n)
    `CHK("busy", 1'b0, busy)
    t_group(18'h03100, 2'b01);
    slow = 1'b1;
    t_group(18'h0ffff, 2'b10);
    slow = 1'b0;
    t_group(18'h00000, 2'b00);
    t_single();
    t_lock(18'h20000, 18'h2ffff, 18'h20010, 2'b00, 0);
    t_lock(18'h03000, 18'h03fff, 18'h0ffff, 2'b01, 2);
    t_lock(18'h00000, 18'h01fff, 18'h04000, 2'b10, 0);
    close_out();
  end
endmodule

// file: rtl/flash_bus_cycle.sv
// Bus-cycle engine: one write or read cycle on the flash pins.
// Assumes the flash latches address and data at the strobe's rising edge.
`timescale 1ns/1ns
module flash_bus_cycle
  import flash_ctl_pkg::*;
(
  input wire logic CLK,                 // System clock
  input wire logic RESET,               // Sync reset, high
  input wire logic start,               // Begin one cycle
  input wire logic is_write,            // 1 write, 0 read
  input wire logic [ADDR_W-1:0] addr,   // Cycle address
  input wire logic [DATA_W-1:0] wdata,  // Write data
  input wire logic [DATA_W-1:0] pin_dq, // Synchronised data in
  output logic done,                    // One-cycle completion
  output logic [DATA_W-1:0] rdata,      // Captured read data
  output logic [ADDR_W-1:0] a_out,      // Address pins
  output logic [DATA_W-1:0] dq_out,     // Data out
  output logic dq_oe,                   // Data drive enable
  output logic ce_n,                    // Chip enable
  output logic we_n,                    // Write enable
  output logic oe_n                     // Output enable
);
  bus_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic wr_q;

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  // Address and data are stable from setup through hold, so both the
  // falling-edge and rising-edge latching styles see valid values.
  always_ff @(posedge CLK) begin
    done <= 1'b0;
    if (RESET) begin
      state_q <= BUS_IDLE;
      cnt_q <= '0;
      wr_q <= 1'b0;
      a_out <= '0;
      dq_out <= '0;
      dq_oe <= 1'b0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      rdata <= '0;
    end else begin
      case (state_q)
        BUS_IDLE: begin
          if (start) begin
            wr_q <= is_write;
            a_out <= addr;
            dq_out <= wdata;
            dq_oe <= is_write;
            ce_n <= 1'b0;
            cnt_q <= CNT_W'(STROBE_HIGH_CYC);
            state_q <= BUS_SETUP;
          end
        end
        BUS_SETUP: begin
          if (cnt_q == '0) begin
            we_n <= ~wr_q;
            oe_n <= wr_q;
            cnt_q <= CNT_W'(STROBE_LOW_CYC);
            state_q <= BUS_STROBE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        BUS_STROBE: begin
          if (cnt_q == '0) begin
            we_n <= 1'b1;         // Rising edge latches addr and data
            oe_n <= 1'b1;
            if (!wr_q) begin
              rdata <= pin_dq;
            end
            cnt_q <= CNT_W'(STROBE_HIGH_CYC);
            state_q <= BUS_HOLD;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        BUS_HOLD: begin
          if (cnt_q == '0) begin
            ce_n <= 1'b1;
            dq_oe <= 1'b0;
            done <= 1'b1;
            state_q <= BUS_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: state_q <= BUS_IDLE;
      endcase
    end
  end
endmodule

// file: rtl/flash_ctl_pkg.sv
// Package: constants for the boot-flash erase/lock controller.
// Assumes a 125 MHz clock and a boot-block flash with asymmetric blocks.
package flash_ctl_pkg;
  // ----------------------------------------------------------------
  // Clock and strobe timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int STROBE_LOW_NS = 64;      // Write strobe low width
  localparam int STROBE_HIGH_NS = 32;     // Setup/hold around strobe
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int UNLOCK_SETTLE_NS = 800;  // High-voltage settle time
  localparam int UNLOCK_SETTLE_CYC =
    (UNLOCK_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;
  // ----------------------------------------------------------------
  // Bus widths and block map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 18;             // Word address, 256K words
  localparam int DATA_W = 16;
  localparam int NUM_GROUP = 4;           // Members of combined group
  // Block base addresses (word), combined group at bottom
  localparam logic [ADDR_W-1:0] BOOT_BASE = 18'h00000;  // 16 Kbyte
  localparam logic [ADDR_W-1:0] PARAM0_BASE = 18'h02000; // 8 Kbyte
  localparam logic [ADDR_W-1:0] PARAM1_BASE = 18'h03000; // 8 Kbyte
  localparam logic [ADDR_W-1:0] SMALL_BASE = 18'h04000;  // 96 Kbyte
  localparam logic [ADDR_W-1:0] GROUP_TOP = 18'h0ffff;   // 128 Kbyte end
  // ----------------------------------------------------------------
  // Flash commands and status
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0020;
  localparam logic [DATA_W-1:0] CMD_ERASE_CONFIRM = 16'h00d0;
  localparam logic [DATA_W-1:0] CMD_READ_STATUS = 16'h0070;
  localparam logic [DATA_W-1:0] CMD_CLEAR_STATUS = 16'h0050;
  localparam logic [DATA_W-1:0] CMD_READ_ARRAY = 16'h00ff;
  localparam int SR_READY_BIT = 7;
  localparam int SR_ERASE_ERR_BIT = 5;
  localparam int SR_VPP_ERR_BIT = 3;
  // ----------------------------------------------------------------
  // Unlock methods
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    UNLOCK_NONE = 2'b00,   // Boot block kept permanently unlocked
    UNLOCK_WP = 2'b01,     // Logic-level write-protect pin
    UNLOCK_HV = 2'b10      // Reset pin to high voltage level
  } unlock_mode_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_SETUP = 2'b01,
    BUS_STROBE = 2'b10,
    BUS_HOLD = 2'b11
  } bus_state_t;
endpackage

// file: rtl/flash_erase_ctl.sv
// Erase and lock controller that drives a boot-block flash over its pins.
// Assumes external switches turn the program and high voltages on and off,
// and that the flash status byte is read back on the data pins.
//
// Overview of operation
// - Erase of any group member erases all four in turn, stopping at the first member that fails
// - Unlock boot block whenever the group is erased
// - No write-protect pin: raise reset to high voltage
// - Cut program voltage on locked-sector addresses
// - Flash runs the erase timing; controller polls the status register
// - Write-protect pin always driven, never floating
`timescale 1ns/1ns
module flash_erase_ctl
  import flash_ctl_pkg::*;
(
  input wire logic CLK,                   // System clock
  input wire logic RESET,                 // Sync reset, high
  input wire logic ERASE_REQ,             // Erase request pulse
  input wire logic [ADDR_W-1:0] ERASE_ADDR, // Any address in block
  input wire logic [1:0] UNLOCK_MODE,     // unlock_mode_t
  input wire logic [ADDR_W-1:0] LOCK_LO,  // Protected range low
  input wire logic [ADDR_W-1:0] LOCK_HI,  // Protected range high
  input wire logic LOCK_EN,               // Enable range protection
  input wire logic [DATA_W-1:0] DQ_IN,    // Flash data pins in
  output logic [DATA_W-1:0] DQ_OUT,       // Flash data pins out
  output logic DQ_OE,                     // Data pin drive enable
  output logic [ADDR_W-1:0] A,            // Flash address pins
  output logic CE_N,                      // Chip enable
  output logic WE_N,                      // Write enable
  output logic OE_N,                      // Output enable
  output logic WRITE_PROTECT_N,           // Write-protect pin level
  output logic RESET_POWERDOWN_N,         // Reset/power-down logic level
  output logic HIGH_VOLTAGE_EN,           // Switch reset pin to 12V
  output logic PROGRAM_VOLTAGE_EN,        // Switch program voltage on
  output logic BUSY,                      // Erase in progress
  output logic ERR,                       // Last erase failed
  output logic ERASE_DONE                 // One-cycle completion
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_UNLOCK = 4'b0001,
    ST_CLR = 4'b0010,
    ST_SETUP = 4'b0011,
    ST_CONFIRM = 4'b0100,
    ST_POLL_CMD = 4'b0101,
    ST_POLL = 4'b0110,
    ST_CHECK = 4'b0111,
    ST_RELOCK = 4'b1000,
    ST_FINISH = 4'b1001
  } erase_state_t;

  erase_state_t state_q;
  logic [DATA_W-1:0] dq_s1_q, dq_s2_q;
  logic [1:0] idx_q;
  logic group_q, fail_q;
  logic [ADDR_W-1:0] blk_q;
  logic [CNT_W-1:0] wait_q;
  logic bus_start, bus_write, bus_done;
  logic [ADDR_W-1:0] bus_addr, tgt_addr;
  logic [DATA_W-1:0] bus_wdata, bus_rdata;
  logic in_group, in_locked;
  unlock_mode_t mode;

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  // Data pins are asynchronous to CLK; two flops before use
  always_ff @(posedge CLK) begin
    if (RESET) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else begin
      dq_s1_q <= DQ_IN;
      dq_s2_q <= dq_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign mode = unlock_mode_t'(UNLOCK_MODE);
  assign in_group = (ERASE_ADDR <= GROUP_TOP);
  // Member base per step; the group always goes boot first
  always_comb begin
    case (idx_q)
      2'd0: tgt_addr = BOOT_BASE;
      2'd1: tgt_addr = PARAM0_BASE;
      2'd2: tgt_addr = PARAM1_BASE;
      default: tgt_addr = SMALL_BASE;
    endcase
    if (!group_q) begin
      tgt_addr = blk_q;
    end
  end
  // Only the boot block has device locking; others protected here
  assign in_locked = LOCK_EN && (bus_addr >= LOCK_LO) &&
                     (bus_addr <= LOCK_HI);

  // ----------------------------------------------------------------
  // Erase sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    ERASE_DONE <= 1'b0;
    if (RESET) begin
      state_q <= ST_IDLE;
      idx_q <= 2'd0;
      group_q <= 1'b0;
      fail_q <= 1'b0;
      blk_q <= '0;
      wait_q <= '0;
      ERR <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (ERASE_REQ) begin
            group_q <= in_group;
            blk_q <= ERASE_ADDR;
            idx_q <= 2'd0;
            fail_q <= 1'b0;
            wait_q <= CNT_W'(UNLOCK_SETTLE_CYC);
            state_q <= ST_UNLOCK;
          end
        end
        ST_UNLOCK: begin
          // Let the unlock level settle before any command
          if (wait_q == '0) begin
            state_q <= ST_CLR;
          end else begin
            wait_q <= wait_q - 1'b1;
          end
        end
        ST_CLR: if (bus_done) state_q <= ST_SETUP;
        ST_SETUP: if (bus_done) state_q <= ST_CONFIRM;
        ST_CONFIRM: if (bus_done) state_q <= ST_POLL_CMD;
        ST_POLL_CMD: if (bus_done) state_q <= ST_POLL;
        ST_POLL: begin
          if (bus_done && bus_rdata[SR_READY_BIT]) begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          // Check each member before issuing the next one
          if (bus_rdata[SR_ERASE_ERR_BIT] || bus_rdata[SR_VPP_ERR_BIT]) begin
            fail_q <= 1'b1;
            state_q <= ST_RELOCK;
          end else if (group_q && idx_q != 2'(NUM_GROUP - 1)) begin
            idx_q <= idx_q + 2'd1;
            state_q <= ST_CLR;
          end else begin
            state_q <= ST_RELOCK;
          end
        end
        ST_RELOCK: if (bus_done) state_q <= ST_FINISH;
        ST_FINISH: begin
          ERR <= fail_q;
          ERASE_DONE <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bus cycle requests
  // ----------------------------------------------------------------
  // A one-cycle request is raised on entry to each bus state; issued_q holds off repeats until done
  logic issued_q;
  always_ff @(posedge CLK) begin
    if (RESET || bus_done) begin
      issued_q <= 1'b0;
    end else if (bus_start) begin
      issued_q <= 1'b1;
    end
  end

  always_comb begin
    bus_start = 1'b0;
    bus_write = 1'b1;
    bus_addr = tgt_addr;
    bus_wdata = CMD_READ_STATUS;
    case (state_q)
      ST_CLR: bus_wdata = CMD_CLEAR_STATUS;
      ST_SETUP: bus_wdata = CMD_ERASE_SETUP;
      ST_CONFIRM: bus_wdata = CMD_ERASE_CONFIRM;
      ST_POLL: bus_write = 1'b0;
      ST_RELOCK: bus_wdata = CMD_READ_ARRAY;
      default: bus_wdata = CMD_READ_STATUS;
    endcase
    case (state_q)
      ST_CLR, ST_SETUP, ST_CONFIRM, ST_POLL_CMD, ST_POLL, ST_RELOCK:
        bus_start = !issued_q;
      default: bus_start = 1'b0;
    endcase
  end

  flash_bus_cycle u_bus (
    .CLK(CLK),
    .RESET(RESET),
    .start(bus_start),
    .is_write(bus_write),
    .addr(bus_addr),
    .wdata(bus_wdata),
    .pin_dq(dq_s2_q),
    .done(bus_done),
    .rdata(bus_rdata),
    .a_out(A),
    .dq_out(DQ_OUT),
    .dq_oe(DQ_OE),
    .ce_n(CE_N),
    .we_n(WE_N),
    .oe_n(OE_N)
  );

  // ----------------------------------------------------------------
  // Lock control pins
  // ----------------------------------------------------------------
  // Outside UNLOCK_NONE, unlock only for the erase; boot block locked again afterwards so
  // stray writes between erases cannot reach it.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      WRITE_PROTECT_N <= 1'b0;       // Driven low, never floating
      HIGH_VOLTAGE_EN <= 1'b0;
      RESET_POWERDOWN_N <= 1'b0;     // Held in reset: all locked
      PROGRAM_VOLTAGE_EN <= 1'b0;
      BUSY <= 1'b0;
    end else begin
      RESET_POWERDOWN_N <= 1'b1;
      BUSY <= (state_q != ST_IDLE);
      if (mode == UNLOCK_NONE) begin
        WRITE_PROTECT_N <= 1'b1;     // Permanently unlocked
        HIGH_VOLTAGE_EN <= 1'b0;
      end else begin
        WRITE_PROTECT_N <= (mode == UNLOCK_WP) &&
                           (state_q != ST_IDLE);
        HIGH_VOLTAGE_EN <= (mode == UNLOCK_HV) &&
                           (state_q != ST_IDLE);
      end
      // Program voltage off for protected sectors and when idle
      PROGRAM_VOLTAGE_EN <= (state_q != ST_IDLE) && !in_locked;
    end
  end
endmodule
